//--- design/ptp_delay_map.vh
`ifndef PTP_DELAY_MAP_VH
`define PTP_DELAY_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_MODE_BASE      12'h000
`define OFS_EDLY_BASE      12'h040
`define OFS_IDLYA_BASE     12'h080
`define OFS_IDLYB_BASE     12'h0C0
`define OFS_TIMING_BASE    12'h100
`define OFS_SMAC_LOW       12'h200
`define OFS_SMAC_HIGH      12'h204
`define OFS_CSUM_DIS       12'h208
`define OFS_FIFO_ADV       12'h20C
`define OFS_FIFO_VAL       12'h210
`define OFS_CPUVD_MODE     12'h214
`define OFS_RSV_STICKY     12'h218
`define OFS_CORR_STICKY    12'h21C
`define OFS_PHY_TIMING     12'h220
`define OFS_PHASE_EVAL     12'h224
`define OFS_SEQ_INDEX      12'h228
`define OFS_SEQ_DATA       12'h22C
`define OFS_COMP_SEL       12'h230
`define OFS_COMP_RESULT    12'h234

// ****************************************
// Field positions
// ****************************************
`define MODE_DOMAIN_LSB    0
`define MODE_PTPMODE_LSB   2
`define TIM_RX_LSB         0
`define TIM_TX_LSB         14
`define TIM_EN_BIT         28
`define TIM_DOMAIN_LSB     29
`define COMP_PORT_LSB      0
`define COMP_SPEED_LSB     4
`define FIFO_VALID_BIT     31

// ****************************************
// Speed codes and delay commands
// ****************************************
`define SPEED_FX100        2'h0
`define SPEED_1G           2'h1
`define SPEED_2G5          2'h2
`define SPEED_10G          2'h3
`define DCMD_NONE          2'h0
`define DCMD_EGRESS        2'h1
`define DCMD_INGRESS_A     2'h2
`define DCMD_INGRESS_B     2'h3

// ****************************************
// Barrel-shift steps in units of 0.01 ns
// ****************************************
`define STEP_1G            16'h0050
`define STEP_2G5           16'h0020
`define STEP_FX            16'h0050

// ****************************************
// Reset values
// ****************************************
`define RST_DOMAIN         2'h0
`define RST_WORD           32'h0000_0000

`endif

//--- design/stamp_fifo.v
`include "ptp_delay_map.vh"

module stamp_fifo #(
	parameter WIDTH = 31,
	parameter ADDR  = 3
) (
	input  wire             core_clk,
	input  wire             rst_b,
	input  wire             clk_en,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	localparam DEPTH = 1 << ADDR;

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [ADDR:0]    wr_ptr_reg;
	reg [ADDR:0]    rd_ptr_reg;
	wire            push;
	wire            pop;

	assign out_valid = (wr_ptr_reg != rd_ptr_reg);
	assign in_ready  = !((wr_ptr_reg[ADDR] != rd_ptr_reg[ADDR]) &&
		(wr_ptr_reg[ADDR-1:0] == rd_ptr_reg[ADDR-1:0]));
	assign push      = in_valid && in_ready && clk_en;
	assign pop       = out_valid && out_ready && clk_en;
	assign out_data  = mem[rd_ptr_reg[ADDR-1:0]];

	always @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_reg[ADDR-1:0]] <= in_data;
		end
	end

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= {(ADDR+1){1'b0}};
			rd_ptr_reg <= {(ADDR+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

endmodule

//--- design/ptp_delay_comp.v
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`include "ptp_delay_map.vh"

module ptp_delay_comp #(
	parameter PORTS     = 11,
	parameter FLOWS     = 256,
	parameter SEQ_W     = 16,
	parameter FIFO_ADDR = 3
) (
	input  wire                core_clk,
	input  wire                rst_b,
	input  wire                clk_en,
	input  wire [11:0]         avs_address,
	input  wire                avs_read,
	input  wire                avs_write,
	input  wire [31:0]         avs_writedata,
	output reg  [31:0]         avs_readdata,
	output reg                 avs_waitrequest,
	input  wire                frame_valid,
	input  wire [1:0]          frame_delay_cmd,
	input  wire [3:0]          frame_tx_port,
	input  wire [3:0]          frame_rx_port,
	output reg                 delay_add_valid,
	output reg  [31:0]         delay_add_value,
	input  wire                stamp_valid,
	input  wire [30:0]         stamp_data,
	output reg                 stamp_ready,
	input  wire [PORTS-1:0]    reserved_nonzero_event,
	input  wire [PORTS-1:0]    correction_overflow_event,
	input  wire [PORTS-1:0]    pcs_link_up,
	input  wire [4*PORTS-1:0]  gig_pcs_link_status,
	input  wire [4*PORTS-1:0]  data_edge_position,
	output reg  [PORTS-1:0]    checksum_update_disable,
	output reg  [PORTS-1:0]    clock_phase_eval_cfg,
	output reg  [15:0]         internal_phy_timing_cfg,
	output reg  [31:0]         replace_srcmac_low,
	output reg  [15:0]         replace_srcmac_high
);

	// ****************************************
	// Storage
	// ****************************************
	reg [3:0]       port_domain_mode_cfg [0:PORTS-1];
	reg [31:0]      egress_optional_delay [0:PORTS-1];
	reg [31:0]      ingress_optional_delay_a [0:PORTS-1];
	reg [31:0]      ingress_optional_delay_b [0:PORTS-1];
	reg [31:0]      port_timing_cfg [0:PORTS-1];
	reg [SEQ_W-1:0] flow_sequence_table [0:FLOWS-1];
	reg [31:0]      stamp_fifo_value;
	reg [3:0]       cpu_virtual_port_mode;
	reg [PORTS-1:0] reserved_nonzero_sticky;
	reg [PORTS-1:0] correction_overflow_sticky;
	reg [7:0]       seq_index_reg;
	reg [5:0]       comp_sel_reg;
	reg [31:0]      comp_result_reg;
	reg [31:0]      rd_next;
	wire            bus_req;
	wire            wr_go;
	wire            adv_go;
	wire            fifo_valid;
	wire            fifo_in_ready;
	wire [30:0]     fifo_head;

	// ****************************************
	// Address decode helpers
	// ****************************************
	function in_bank;
		input [11:0] addr;
		input [11:0] base;
		begin
			in_bank = (addr[11:6] == base[11:6]) && (addr[5:2] < PORTS) && (addr[1:0] == 2'h0);
		end
	endfunction

	function [3:0] bank_port;
		input [11:0] addr;
		begin
			bank_port = addr[5:2];
		end
	endfunction

	assign bus_req = (avs_read || avs_write) && clk_en;
	assign wr_go   = avs_write && !avs_waitrequest && clk_en;
	assign adv_go  = wr_go && (avs_address == `OFS_FIFO_ADV);

	// ****************************************
	// Waitrequest: one wait state per access
	// ****************************************
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= `RST_WORD;
		end else if (clk_en) begin
			avs_waitrequest <= !(bus_req && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= rd_next;
			end
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	always @* begin
		rd_next = `RST_WORD;
		if (in_bank(avs_address, `OFS_MODE_BASE)) begin
			rd_next = {28'h0, port_domain_mode_cfg[bank_port(avs_address)]};
		end else if (in_bank(avs_address, `OFS_EDLY_BASE)) begin
			rd_next = egress_optional_delay[bank_port(avs_address)];
		end else if (in_bank(avs_address, `OFS_IDLYA_BASE)) begin
			rd_next = ingress_optional_delay_a[bank_port(avs_address)];
		end else if (in_bank(avs_address, `OFS_IDLYB_BASE)) begin
			rd_next = ingress_optional_delay_b[bank_port(avs_address)];
		end else if (in_bank(avs_address, `OFS_TIMING_BASE)) begin
			rd_next = port_timing_cfg[bank_port(avs_address)];
		end else begin
			case (avs_address)
				`OFS_SMAC_LOW:    rd_next = replace_srcmac_low;
				`OFS_SMAC_HIGH:   rd_next = {16'h0, replace_srcmac_high};
				`OFS_CSUM_DIS:    rd_next[PORTS-1:0] = checksum_update_disable;
				`OFS_FIFO_VAL:    rd_next = stamp_fifo_value;
				`OFS_CPUVD_MODE:  rd_next = {28'h0, cpu_virtual_port_mode};
				`OFS_RSV_STICKY:  rd_next[PORTS-1:0] = reserved_nonzero_sticky;
				`OFS_CORR_STICKY: rd_next[PORTS-1:0] = correction_overflow_sticky;
				`OFS_PHY_TIMING:  rd_next = {16'h0, internal_phy_timing_cfg};
				`OFS_PHASE_EVAL:  rd_next[PORTS-1:0] = clock_phase_eval_cfg;
				`OFS_SEQ_INDEX:   rd_next = {24'h0, seq_index_reg};
				`OFS_SEQ_DATA:    rd_next[SEQ_W-1:0] = flow_sequence_table[seq_index_reg];
				`OFS_COMP_SEL:    rd_next = {26'h0, comp_sel_reg};
				`OFS_COMP_RESULT: rd_next = comp_result_reg;
				default:          rd_next = `RST_WORD;
			endcase
		end
	end

	// ****************************************
	// Per-port configuration banks
	// ****************************************
	genvar p;
	generate
		for (p = 0; p < PORTS; p = p + 1) begin : g_port
			always @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					port_domain_mode_cfg[p]     <= {2'h0, `RST_DOMAIN};
					egress_optional_delay[p]    <= `RST_WORD;
					ingress_optional_delay_a[p] <= `RST_WORD;
					ingress_optional_delay_b[p] <= `RST_WORD;
					port_timing_cfg[p]          <= `RST_WORD;
				end else if (wr_go) begin
					if (avs_address == (`OFS_MODE_BASE + 4 * p)) begin
						port_domain_mode_cfg[p] <= avs_writedata[3:0];
					end
					if (avs_address == (`OFS_EDLY_BASE + 4 * p)) begin
						egress_optional_delay[p] <= avs_writedata;
					end
					if (avs_address == (`OFS_IDLYA_BASE + 4 * p)) begin
						ingress_optional_delay_a[p] <= avs_writedata;
					end
					if (avs_address == (`OFS_IDLYB_BASE + 4 * p)) begin
						ingress_optional_delay_b[p] <= avs_writedata;
					end
					if (avs_address == (`OFS_TIMING_BASE + 4 * p)) begin
						port_timing_cfg[p] <= avs_writedata;
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Global configuration and sticky flags
	// ****************************************
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			replace_srcmac_low         <= `RST_WORD;
			replace_srcmac_high        <= 16'h0000;
			checksum_update_disable    <= {PORTS{1'b0}};
			cpu_virtual_port_mode      <= 4'h0;
			internal_phy_timing_cfg    <= 16'h0000;
			clock_phase_eval_cfg       <= {PORTS{1'b0}};
			seq_index_reg              <= 8'h00;
			comp_sel_reg               <= 6'h00;
			reserved_nonzero_sticky    <= {PORTS{1'b0}};
			correction_overflow_sticky <= {PORTS{1'b0}};
		end else if (clk_en) begin
			if (wr_go) begin
				case (avs_address)
					`OFS_SMAC_LOW:   replace_srcmac_low <= avs_writedata;
					`OFS_SMAC_HIGH:  replace_srcmac_high <= avs_writedata[15:0];
					`OFS_CSUM_DIS:   checksum_update_disable <= avs_writedata[PORTS-1:0];
					`OFS_CPUVD_MODE: cpu_virtual_port_mode <= avs_writedata[3:0];
					`OFS_PHY_TIMING: internal_phy_timing_cfg <= avs_writedata[15:0];
					`OFS_PHASE_EVAL: clock_phase_eval_cfg <= avs_writedata[PORTS-1:0];
					`OFS_SEQ_INDEX:  seq_index_reg <= avs_writedata[7:0];
					`OFS_COMP_SEL:   comp_sel_reg <= avs_writedata[5:0];
					default: begin
					end
				endcase
			end
			// Write one to clear; a new event in the same cycle wins
			reserved_nonzero_sticky <= reserved_nonzero_event |
				(reserved_nonzero_sticky & ~((wr_go && avs_address == `OFS_RSV_STICKY) ?
				avs_writedata[PORTS-1:0] : {PORTS{1'b0}}));
			correction_overflow_sticky <= correction_overflow_event |
				(correction_overflow_sticky & ~((wr_go && avs_address == `OFS_CORR_STICKY) ?
				avs_writedata[PORTS-1:0] : {PORTS{1'b0}}));
		end
	end

	// ****************************************
	// Sequence number table
	// ****************************************
	always @(posedge core_clk) begin
		if (wr_go && avs_address == `OFS_SEQ_DATA) begin
			flow_sequence_table[seq_index_reg] <= avs_writedata[SEQ_W-1:0];
		end
	end

	// ****************************************
	// Two-step stamp FIFO
	// ****************************************
	stamp_fifo #(
		.WIDTH (31),
		.ADDR  (FIFO_ADDR)
	) u_stamp_fifo (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.clk_en    (clk_en),
		.in_valid  (stamp_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (stamp_data),
		.out_valid (fifo_valid),
		.out_ready (adv_go),
		.out_data  (fifo_head)
	);

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			stamp_fifo_value <= `RST_WORD;
			stamp_ready      <= 1'b0;
		end else if (clk_en) begin
			stamp_ready <= fifo_in_ready;
			if (adv_go) begin
				stamp_fifo_value <= {fifo_valid, fifo_valid ? fifo_head : 31'h0};
			end
		end
	end

	// ****************************************
	// Frame delay command
	// ****************************************
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			delay_add_valid <= 1'b0;
			delay_add_value <= `RST_WORD;
		end else if (clk_en) begin
			delay_add_valid <= frame_valid;
			if (frame_valid) begin
				case (frame_delay_cmd)
					`DCMD_EGRESS:    delay_add_value <= egress_optional_delay[frame_tx_port];
					`DCMD_INGRESS_A: delay_add_value <= ingress_optional_delay_a[frame_rx_port];
					`DCMD_INGRESS_B: delay_add_value <= ingress_optional_delay_b[frame_rx_port];
					default:         delay_add_value <= `RST_WORD;
				endcase
			end
		end
	end

	// ****************************************
	// Receive delay compensation
	// ****************************************
	wire [3:0]  comp_port  = comp_sel_reg[`COMP_PORT_LSB +: 4];
	wire [1:0]  comp_speed = comp_sel_reg[`COMP_SPEED_LSB +: 2];
	wire [31:0] comp_cfg   = port_timing_cfg[comp_port];
	wire [15:0] comp_base  = {2'h0, comp_cfg[`TIM_RX_LSB +: 14]};
	wire [3:0]  comp_var   = gig_pcs_link_status[4 * comp_port +: 4];
	wire [3:0]  comp_edge  = data_edge_position[4 * comp_port +: 4];
	reg  [15:0] comp_next;

	always @* begin
		comp_next = comp_base;
		case (comp_speed)
			`SPEED_1G: begin
				comp_next = comp_base + (`STEP_1G * {12'h0, comp_var});
			end
			`SPEED_2G5: begin
				comp_next = comp_base + (`STEP_2G5 * {12'h0, comp_var});
			end
			`SPEED_FX100: begin
				comp_next = comp_base - (`STEP_FX * {12'h0, comp_edge});
			end
			default: begin
				comp_next = comp_base;
			end
		endcase
	end

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			comp_result_reg <= `RST_WORD;
		end else if (clk_en) begin
			if (comp_port < PORTS && pcs_link_up[comp_port]) begin
				comp_result_reg <= {1'b1, 15'h0, comp_next};
			end else begin
				comp_result_reg <= `RST_WORD;
			end
		end
	end

endmodule

//--- dv/delay_comp_properties.sv
module delay_comp_checker #(
	parameter PORTS = 11
) (
	input logic             core_clk,
	input logic             rst_b,
	input logic             clk_en,
	input logic [11:0]      avs_address,
	input logic             avs_read,
	input logic             avs_write,
	input logic             avs_waitrequest,
	input logic             frame_valid,
	input logic [1:0]       frame_delay_cmd,
	input logic             delay_add_valid,
	input logic [31:0]      delay_add_value,
	input logic [PORTS-1:0] checksum_update_disable,
	input logic [PORTS-1:0] clock_phase_eval_cfg,
	input logic [15:0]      internal_phy_timing_cfg,
	input logic [31:0]      replace_srcmac_low,
	input logic [15:0]      replace_srcmac_high
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// ****************************************
	// Bus handshake, frame path and configuration writes
	// ****************************************
	sequence bus_taken;
		clk_en && (avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence bus_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	a_bus_one_wait: assert property (bus_taken |=> bus_answer)
		else $error("bus answer not after one wait state");
	a_bus_no_answer: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
		else $error("bus answered without request");
	a_frame_answer: assert property (frame_valid && clk_en |=> delay_add_valid)
		else $error("delay valid missing after frame");
	a_frame_quiet: assert property (!frame_valid && clk_en |=> !delay_add_valid)
		else $error("delay valid without frame");
	a_cmd_none_zero: assert property (frame_valid && clk_en && frame_delay_cmd == 2'h0
		|=> delay_add_value == 32'h0000_0000)
		else $error("no-delay command gave nonzero delay");
	a_value_holds: assert property (!frame_valid && clk_en |=> $stable(delay_add_value))
		else $error("delay value changed between frames");
	a_csum_by_write: assert property ($changed(checksum_update_disable)
		|-> $past(avs_write && !avs_waitrequest && avs_address == 12'h208))
		else $error("checksum disable changed without write");
	a_smac_by_write: assert property ($changed(replace_srcmac_low) || $changed(replace_srcmac_high)
		|-> $past(avs_write && !avs_waitrequest && (avs_address == 12'h200 || avs_address == 12'h204)))
		else $error("replacement address changed without write");
	a_phy_by_write: assert property ($changed(internal_phy_timing_cfg)
		|-> $past(avs_write && !avs_waitrequest && avs_address == 12'h220))
		else $error("phy timing changed without write");
	a_phase_by_write: assert property ($changed(clock_phase_eval_cfg)
		|-> $past(avs_write && !avs_waitrequest && avs_address == 12'h224))
		else $error("phase eval changed without write");
endmodule

bind ptp_delay_comp delay_comp_checker #(.PORTS(PORTS)) u_checker (.*);

//--- dv/link_partner_model.sv
module link_partner_model #(
	parameter PORTS = 11
) (
	input  logic               core_clk,
	input  logic               rst_b,
	input  logic [PORTS-1:0]   link_mask,
	input  logic [3:0]         var_val,
	input  logic [3:0]         edge_val,
	input  logic [PORTS-1:0]   rsv_mask,
	input  logic [PORTS-1:0]   cor_mask,
	input  logic               stamp_go,
	input  logic [30:0]        stamp_in,
	input  logic               stamp_ready,
	output logic [PORTS-1:0]   pcs_link_up,
	output logic [4*PORTS-1:0] gig_pcs_link_status,
	output logic [4*PORTS-1:0] data_edge_position,
	output logic [PORTS-1:0]   reserved_nonzero_event,
	output logic [PORTS-1:0]   correction_overflow_event,
	output logic               stamp_valid,
	output logic [30:0]        stamp_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pending;
	// ****************************************
	// Link status, events and stamp pushes
	// ****************************************
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pcs_link_up <= '0;
			gig_pcs_link_status <= '0;
			data_edge_position <= '0;
			reserved_nonzero_event <= '0;
			correction_overflow_event <= '0;
			stamp_valid <= 1'b0;
			stamp_data <= 31'h0000_0000;
			pending <= 1'b0;
		end else begin
			pcs_link_up <= link_mask;
			gig_pcs_link_status <= {PORTS{var_val}};
			data_edge_position <= {PORTS{edge_val}};
			reserved_nonzero_event <= rsv_mask;
			correction_overflow_event <= cor_mask;
			stamp_valid <= 1'b0;
			if (stamp_go)
				pending <= 1'b1;
			if (pending && stamp_ready && !stamp_valid) begin
				stamp_valid <= 1'b1;
				stamp_data <= stamp_in;
				pending <= 1'b0;
			end else
				stamp_data <= ~stamp_data;
		end
	end
endmodule

//--- dv/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam PORTS = 11;
	logic               core_clk, rst_b, clk_en, avs_read, avs_write, avs_waitrequest;
	logic [11:0]        avs_address;
	logic [31:0]        avs_writedata, avs_readdata, delay_add_value, replace_srcmac_low, rdata;
	logic               frame_valid, delay_add_valid, stamp_valid, stamp_ready, stamp_go;
	logic [1:0]         frame_delay_cmd;
	logic [3:0]         frame_tx_port, frame_rx_port, var_val, edge_val;
	logic [30:0]        stamp_data, stamp_in;
	logic [PORTS-1:0]   reserved_nonzero_event, correction_overflow_event, pcs_link_up;
	logic [PORTS-1:0]   checksum_update_disable, clock_phase_eval_cfg, link_mask, rsv_mask, cor_mask;
	logic [4*PORTS-1:0] gig_pcs_link_status, data_edge_position;
	logic [15:0]        internal_phy_timing_cfg, replace_srcmac_high, exp_rx;
	logic [3:0]         cp[4]  = '{4'h1, 4'h5, 4'h7, 4'h9};
	logic [1:0]         csp[4] = '{2'h1, 2'h2, 2'h0, 2'h3};
	logic [13:0]        crx[4] = '{14'h1130, 14'h0898, 14'h3052, 14'h2BAC};
	logic [13:0]        ctx[4] = '{14'h1144, 14'h0582, 14'h2C2E, 14'h3F52};
	int                 n_fail, comparisons, cycles, i;
	ptp_delay_comp dut (.*);
	link_partner_model partner (.*);
	// ****************************************
	// Clock, timeout and bus tasks
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		cycles = 0;
		forever begin
			@(posedge core_clk);
			cycles++;
			if (cycles == 20000) begin
				n_fail++;
				finish_test();
			end
		end
	end
	task finish_test();
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task access(input logic wr, input logic [11:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge core_clk);
		rdata = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		access(1'b0, a, 32'h0000_0000);
		check(rdata, exp);
	endtask
	task frame(input logic [1:0] c, input logic [31:0] exp);
		frame_delay_cmd <= c;
		frame_valid <= 1'b1;
		@(posedge core_clk);
		frame_valid <= 1'b0;
		#1;
		check({31'h0, delay_add_valid}, 32'h0000_0001);
		check(delay_add_value, exp);
		@(posedge core_clk);
	endtask
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		{rst_b, avs_read, avs_write, frame_valid, stamp_go} = 5'h00;
		{avs_address, avs_writedata, stamp_in} = '0;
		{frame_delay_cmd, frame_tx_port, frame_rx_port, var_val, edge_val} = '0;
		{link_mask, rsv_mask, cor_mask} = '0;
		{clk_en, n_fail, comparisons} = '0;
		clk_en = 1'b1;
		repeat (20) @(posedge core_clk);
		check({31'h0, stamp_ready}, 32'h0000_0000);
		rst_b <= 1'b1;
		@(posedge core_clk);
		rd(12'h028, 32'h0000_0000);
		check({31'h0, stamp_ready}, 32'h0000_0001);
		rd(12'h208, 32'h0000_0000);
		rd(12'hFFC, 32'h0000_0000);
		for (i = 0; i < PORTS; i++)
			access(1'b1, 12'(4 * i), 32'(i % 3 + 4 * (i % 4)));
		for (i = 0; i < PORTS; i++)
			rd(12'(4 * i), 32'(i % 3 + 4 * (i % 4)));
		access(1'b1, 12'h214, 32'h0000_0009);
		rd(12'h214, 32'h0000_0009);
		access(1'b1, 12'h048, 32'h0000_0111);
		access(1'b1, 12'h094, 32'h0000_0222);
		access(1'b1, 12'h0D4, 32'h0000_0333);
		frame_tx_port <= 4'h2;
		frame_rx_port <= 4'h5;
		frame(2'h0, 32'h0000_0000);
		frame(2'h1, 32'h0000_0111);
		frame(2'h2, 32'h0000_0222);
		frame(2'h3, 32'h0000_0333);
		frame(2'h0, 32'h0000_0000);
		clk_en <= 1'b0;
		frame_delay_cmd <= 2'h1;
		frame_valid <= 1'b1;
		@(posedge core_clk);
		frame_valid <= 1'b0;
		clk_en <= 1'b1;
		@(posedge core_clk);
		check({31'h0, delay_add_valid}, 32'h0000_0000);
		check(delay_add_value, 32'h0000_0000);
		access(1'b1, 12'h200, 32'hA5A5_0F0F);
		access(1'b1, 12'h204, 32'h0000_1234);
		check(replace_srcmac_low, 32'hA5A5_0F0F);
		check({16'h0000, replace_srcmac_high}, 32'h0000_1234);
		access(1'b1, 12'h208, 32'h0000_0505);
		check({21'h0, checksum_update_disable}, 32'h0000_0505);
		access(1'b1, 12'h224, 32'h0000_02A0);
		check({21'h0, clock_phase_eval_cfg}, 32'h0000_02A0);
		access(1'b1, 12'h220, 32'h0000_C3A5);
		check({16'h0000, internal_phy_timing_cfg}, 32'h0000_C3A5);
		rsv_mask <= 11'h008;
		cor_mask <= 11'h400;
		@(posedge core_clk);
		rsv_mask <= 11'h000;
		cor_mask <= 11'h000;
		repeat (2) @(posedge core_clk);
		rd(12'h218, 32'h0000_0008);
		rd(12'h21C, 32'h0000_0400);
		rd(12'h218, 32'h0000_0008);
		access(1'b1, 12'h218, 32'h0000_0008);
		access(1'b1, 12'h21C, 32'h0000_0400);
		rd(12'h218, 32'h0000_0000);
		rd(12'h21C, 32'h0000_0000);
		access(1'b1, 12'h228, 32'h0000_0000);
		access(1'b1, 12'h22C, 32'h0000_BEEF);
		access(1'b1, 12'h228, 32'h0000_00FF);
		access(1'b1, 12'h22C, 32'h0000_1234);
		rd(12'h22C, 32'h0000_1234);
		access(1'b1, 12'h228, 32'h0000_0000);
		rd(12'h22C, 32'h0000_BEEF);
		access(1'b1, 12'h20C, 32'h0000_0000);
		rd(12'h210, 32'h0000_0000);
		for (i = 0; i < 2; i++) begin
			stamp_in <= 31'h1234_5670 + 31'(i);
			stamp_go <= 1'b1;
			@(posedge core_clk);
			stamp_go <= 1'b0;
			repeat (4) @(posedge core_clk);
		end
		for (i = 0; i < 3; i++) begin
			access(1'b1, 12'h20C, 32'h0000_0000);
			rd(12'h210, i < 2 ? {1'b1, 31'h1234_5670 + 31'(i)} : 32'h0000_0000);
		end
		var_val <= 4'h3;
		edge_val <= 4'h2;
		for (i = 0; i < 4; i++) begin
			link_mask <= 11'h001 << cp[i];
			repeat (3) @(posedge core_clk);
			access(1'b1, 12'h100 + 12'(4 * cp[i]), {3'h1, ctx[i], crx[i]});
			rd(12'h100 + 12'(4 * cp[i]), {3'h1, ctx[i], crx[i]});
			exp_rx = {2'h0, crx[i]};
			if (csp[i] == 2'h1)
				exp_rx = exp_rx + 16'h0050 * 16'h0003;
			if (csp[i] == 2'h2)
				exp_rx = exp_rx + 16'h0020 * 16'h0003;
			if (csp[i] == 2'h0)
				exp_rx = exp_rx - 16'h0050 * 16'h0002;
			access(1'b1, 12'h230, {26'h0, csp[i], cp[i]});
			rd(12'h234, {16'h8000, exp_rx});
		end
		link_mask <= 11'h000;
		repeat (3) @(posedge core_clk);
		access(1'b0, 12'h234, 32'h0000_0000);
		check({31'h0, rdata[31]}, 32'h0000_0000);
		finish_test();
	end
endmodule
